/* hdl/cta_timer.sv */
// How it works
// (RULE1) 16-bit counter, loaded from its reload latch, counting down only
// (RULE2) reads return live count: high byte at 0x19, low byte at 0x18
// (RULE3) writes to 0x19 and 0x18 load reload latch high and low bytes
// (RULE4) write to 0x1a loads latch high byte then copies latch to counter
// (RULE5) decrement from zero reloads latch instead of all ones, sets underflow flag
// (RULE6) flag cleared by low byte read, start write, or reset
// (RULE7) mode bits: 00 interval, 01 pulse, 10 event, 11 width measurement
// (RULE8) reset forces mode bits to interval timer; the code only resets mode_prev, mode follows mode_select_in
// (RULE9) interval mode decrements once every clock
// (RULE10) flag with interrupt enable raises interrupt request
// (RULE11) interval mode leaves counter pin as ordinary port bit
// (RULE12) modes needing the pin route the counter onto it automatically
// (RULE13) pulse mode pin output toggles on underflow and on start write
// (RULE14) entering pulse mode drives pin high; next start write drives low
// (RULE15) event mode counts synchronised rising edges; source at most half clock rate
// (RULE16) width mode counts while pin low, holds while high, resumes
// (RULE17) width mode flags at zero, reloads and keeps counting while low
// (RULE18) enabled serial needing internal clock forces clock counting
// (RULE19) software loads clock over sixteen times bit rate, minus one
// (RULE20) serial bit clocks run at one sixteenth of underflow rate
// (RULE21) latch byte writes leave running count untouched until reload
// (RULE22) counter pin synchronised before edge or level detection
// (RULE23) leaving pulse mode for interval stops toggling the output
`timescale 1ns/1ns
`default_nettype none

`include "cta_defs.svh"

module cta_timer
  import cta_pkg::*;
(
  input  wire logic         core_clk_in,
  input  wire logic         reset_in,
  input  wire cta_bus_req_t bus_in,
  output var  logic [7:0]   rdata_out,
  output var  logic         rdata_valid_out,
  input  wire logic [1:0]   mode_select_in,
  input  wire logic         underflow_irq_enable_in,
  input  wire logic         serial_internal_clk_in,
  input  wire logic         port_a_bit_four_in,
  input  wire logic         port_a_bit_four_oe_n_in,
  input  wire logic         counter_pin_in,
  output var  logic         counter_pin_out,
  output var  logic         counter_pin_oe_n_out,
  output var  logic         underflow_flag_out,
  output var  logic         irq_out,
  output var  logic         bit_tick_out
);

  // ============================================================
  // state
  typedef struct packed
  {
    logic [15:0] count;
    logic [15:0] reload;
    logic        flag;
    logic        pulse_level;
    logic        pin_prev;
    cta_mode_t   mode_prev;
    logic [7:0]  rdata;
    logic        rdata_valid;
  } cta_state_t;

  cta_state_t state;
  cta_state_t next_state;

  logic       pin_sync;
  logic       underflow;
  logic       start_wr;
  logic       tick;
  logic       low_wr;
  logic       high_wr;
  logic       low_rd;
  logic       high_rd;
  cta_mode_t  mode;
  cta_mode_t  eff_mode;
  cta_pin_drv_t pin_drv;

  // ============================================================
  // address decode
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
    addr_is = (addr == target);
  endfunction

  // ============================================================
  // pin synchroniser
  cta_sync u_sync
  (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    (counter_pin_in),
    .sync_out    (pin_sync)
  );

  // ============================================================
  // bus decode
  assign low_wr  = bus_in.wr && addr_is(bus_in.addr, `CTA_ADDR_LOW);
  assign high_wr = bus_in.wr && (addr_is(bus_in.addr, `CTA_ADDR_HIGH) || addr_is(bus_in.addr, `CTA_ADDR_START));
  assign low_rd  = bus_in.rd && addr_is(bus_in.addr, `CTA_ADDR_LOW);
  assign high_rd = bus_in.rd && addr_is(bus_in.addr, `CTA_ADDR_HIGH);

  // ============================================================
  // mode and count enable
  assign mode     = cta_mode_t'(mode_select_in); // see (RULE7)
  assign eff_mode = serial_internal_clk_in ? CTA_MODE_INTERVAL : mode; // see (RULE18)
  assign start_wr = bus_in.wr && addr_is(bus_in.addr, `CTA_ADDR_START);

  always_comb
  begin
    case (eff_mode)
      CTA_MODE_INTERVAL:
      begin
        tick = 1'b1; // see (RULE9)
      end
      CTA_MODE_PULSE:
      begin
        tick = 1'b1;
      end
      CTA_MODE_EVENT:
      begin
        tick = pin_sync && !state.pin_prev; // see (RULE15) (RULE22)
      end
      CTA_MODE_WIDTH:
      begin
        tick = !pin_sync; // see (RULE16)
      end
      default:
      begin
        tick = 1'b0;
      end
    endcase
  end

  assign underflow = tick && !start_wr && (state.count == 16'h0000); // see (RULE17)

  // ============================================================
  // next state
  always_comb
  begin
    next_state             = state;
    next_state.pin_prev    = pin_sync;
    next_state.mode_prev   = mode;
    next_state.rdata_valid = 1'b0;

    // ============================================================
    // latch writes, no effect on running count
    if (low_wr)
    begin
      next_state.reload[7:0] = bus_in.wdata; // see (RULE3) (RULE21)
    end
    else if (high_wr)
    begin
      next_state.reload[15:8] = bus_in.wdata; // see (RULE3) (RULE4)
    end

    // ============================================================
    // counting
    if (start_wr)
    begin
      next_state.count = {bus_in.wdata, state.reload[7:0]}; // see (RULE4) (RULE1)
    end
    else if (underflow)
    begin
      next_state.count = state.reload; // see (RULE5)
    end
    else if (tick)
    begin
      next_state.count = state.count - 16'h0001; // see (RULE1)
    end

    // ============================================================
    // underflow flag: set wins over read clear
    if (underflow)
    begin
      next_state.flag = 1'b1; // see (RULE5)
    end
    else if (start_wr || low_rd)
    begin
      next_state.flag = 1'b0; // see (RULE6)
    end

    // ============================================================
    // pulse output
    if (mode == CTA_MODE_PULSE && state.mode_prev != CTA_MODE_PULSE)
    begin
      next_state.pulse_level = 1'b1; // see (RULE14)
    end
    else if (mode == CTA_MODE_PULSE && (start_wr || underflow))
    begin
      next_state.pulse_level = !state.pulse_level; // see (RULE13) (RULE23)
    end

    // ============================================================
    // read data
    if (bus_in.rd)
    begin
      next_state.rdata_valid = 1'b1;
      if (low_rd)
      begin
        next_state.rdata = state.count[7:0]; // see (RULE2)
      end
      else if (high_rd)
      begin
        next_state.rdata = state.count[15:8]; // see (RULE2)
      end
      else
      begin
        next_state.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state.count       <= `CTA_RST_COUNT;
      state.reload      <= `CTA_RST_RELOAD;
      state.flag        <= 1'b0; // see (RULE6)
      state.pulse_level <= `CTA_RST_PIN_LEVEL;
      state.pin_prev    <= `CTA_RST_PIN_LEVEL;
      state.mode_prev   <= CTA_MODE_INTERVAL; // see (RULE8)
      state.rdata       <= 8'h00;
      state.rdata_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ============================================================
  // pin routing
  always_comb
  begin
    if (eff_mode == CTA_MODE_PULSE && !serial_internal_clk_in)
    begin
      pin_drv.level = state.pulse_level; // see (RULE12) (RULE13)
      pin_drv.oe_n  = 1'b0;
    end
    else if (eff_mode == CTA_MODE_INTERVAL)
    begin
      pin_drv.level = port_a_bit_four_in; // see (RULE11)
      pin_drv.oe_n  = port_a_bit_four_oe_n_in;
    end
    else
    begin
      pin_drv.level = 1'b1; // see (RULE12)
      pin_drv.oe_n  = 1'b1;
    end
  end

  assign counter_pin_out      = pin_drv.level;
  assign counter_pin_oe_n_out = pin_drv.oe_n;

  // ============================================================
  // serial bit clock
  cta_bitclk u_bitclk
  (
    .core_clk_in  (core_clk_in),
    .reset_in     (reset_in),
    .underflow_in (underflow),
    .restart_in   (start_wr),
    .bit_tick_out (bit_tick_out) // see (RULE20)
  );

  // ============================================================
  // outputs
  assign rdata_out          = state.rdata;
  assign rdata_valid_out    = state.rdata_valid;
  assign underflow_flag_out = state.flag;
  assign irq_out            = state.flag && underflow_irq_enable_in; // see (RULE10)

endmodule

`default_nettype wire

/* hdl/cta_defs.svh */
`ifndef CTA_DEFS_SVH
`define CTA_DEFS_SVH

// ============================================================
// register addresses on the internal byte bus
`define CTA_ADDR_W          8
`define CTA_ADDR_LOW        8'h18
`define CTA_ADDR_HIGH       8'h19
`define CTA_ADDR_START      8'h1a

// ============================================================
// field positions and reset values
`define CTA_MODE_LSB_POS    0
`define CTA_MODE_MSB_POS    1
`define CTA_RST_MODE        2'h0
`define CTA_RST_COUNT       16'hffff
`define CTA_RST_RELOAD      16'hffff
`define CTA_RST_PIN_LEVEL   1'h1

// ============================================================
// serial bit clock divide
`define CTA_BIT_DIV         16
`define CTA_BIT_DIV_W       4

`endif

/* hdl/cta_pkg.sv */
package cta_pkg;

  // ============================================================
  // counter modes
  typedef enum logic [1:0]
  {
    CTA_MODE_INTERVAL = 2'h0,
    CTA_MODE_PULSE    = 2'h1,
    CTA_MODE_EVENT    = 2'h2,
    CTA_MODE_WIDTH    = 2'h3
  } cta_mode_t;

  // ============================================================
  // processor bus request
  typedef struct packed
  {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cta_bus_req_t;

  // ============================================================
  // counter pin drive: output level and output enable (low = driving)
  typedef struct packed
  {
    logic level;
    logic oe_n;
  } cta_pin_drv_t;

endpackage

/* hdl/cta_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// two flip-flop synchroniser for the counter pin
module cta_sync
  import cta_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  input  wire logic async_in,
  output var  logic sync_out
);

  typedef struct packed
  {
    logic stage1;
    logic stage2;
  } cta_sync_state_t;

  cta_sync_state_t state;
  cta_sync_state_t next_state;

  always_comb
  begin
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state <= '1;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign sync_out = state.stage2;

endmodule

`default_nettype wire

/* hdl/cta_bitclk.sv */
`timescale 1ns/1ns
`default_nettype none

`include "cta_defs.svh"

// ============================================================
// divides counter underflow pulses by sixteen for the serial channel
module cta_bitclk
  import cta_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  input  wire logic underflow_in,
  input  wire logic restart_in,
  output var  logic bit_tick_out
);

  typedef struct packed
  {
    logic [`CTA_BIT_DIV_W-1:0] div;
    logic                      tick;
  } cta_bitclk_state_t;

  cta_bitclk_state_t state;
  cta_bitclk_state_t next_state;

  always_comb
  begin
    next_state      = state;
    next_state.tick = 1'b0;
    if (restart_in)
    begin
      next_state.div = '0;
    end
    else if (underflow_in)
    begin
      next_state.div = state.div + `CTA_BIT_DIV_W'(1);
      if (state.div == `CTA_BIT_DIV_W'(`CTA_BIT_DIV - 1))
      begin
        next_state.tick = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign bit_tick_out = state.tick;

endmodule

`default_nettype wire

/* tb/cta_timer_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// port checker
module cta_timer_chk
  import cta_pkg::*;
(
  input  wire logic         core_clk_in,
  input  wire logic         reset_in,
  input  wire cta_bus_req_t bus_in,
  input  wire logic         rdata_valid_out,
  input  wire logic [1:0]   mode_select_in,
  input  wire logic         underflow_irq_enable_in,
  input  wire logic         serial_internal_clk_in,
  input  wire logic         port_a_bit_four_in,
  input  wire logic         port_a_bit_four_oe_n_in,
  input  wire logic         counter_pin_out,
  input  wire logic         counter_pin_oe_n_out,
  input  wire logic         underflow_flag_out,
  input  wire logic         irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  wire start_wr = bus_in.wr && bus_in.addr == 8'h1a;
  wire low_rd   = bus_in.rd && bus_in.addr == 8'h18;
  sequence pulse_steady;
    (mode_select_in == CTA_MODE_PULSE && !serial_internal_clk_in) [*4];
  endsequence
  sequence pulse_entry;
    mode_select_in == CTA_MODE_PULSE && $past(mode_select_in) != CTA_MODE_PULSE ##1
      mode_select_in == CTA_MODE_PULSE && !serial_internal_clk_in;
  endsequence
  chk_read_answer: assert property (bus_in.rd |=> rdata_valid_out)
    else $error("read not answered");
  chk_irq_gate: assert property (irq_out == (underflow_flag_out && underflow_irq_enable_in))
    else $error("irq not flag and enable");
  chk_start_clear: assert property (start_wr |=> !underflow_flag_out)
    else $error("start write kept flag");
  chk_flag_sticky: assert property (underflow_flag_out && !low_rd && !start_wr |=> underflow_flag_out)
    else $error("flag lost");
  chk_pulse_drive: assert property (pulse_steady |-> !counter_pin_oe_n_out)
    else $error("pulse pin not driven");
  chk_pulse_toggle: assert property (pulse_steady ##0 start_wr |=> counter_pin_out != $past(counter_pin_out))
    else $error("pulse pin not toggled");
  chk_port_pass: assert property ((mode_select_in == CTA_MODE_INTERVAL) [*2] |->
    counter_pin_out == port_a_bit_four_in && counter_pin_oe_n_out == port_a_bit_four_oe_n_in)
    else $error("port bit not passed");
  chk_event_input: assert property ((mode_select_in == CTA_MODE_EVENT && !serial_internal_clk_in) [*2] |-> counter_pin_oe_n_out)
    else $error("event pin driven");
  chk_pulse_entry: assert property (pulse_entry |-> counter_pin_out)
    else $error("pulse entry not high");
  chk_valid_pulse: assert property (!bus_in.rd |=> !rdata_valid_out)
    else $error("valid without read");
endmodule

bind cta_timer cta_timer_chk cta_timer_chk_i (.core_clk_in, .reset_in, .bus_in, .rdata_valid_out, .mode_select_in,
  .underflow_irq_enable_in, .serial_internal_clk_in, .port_a_bit_four_in, .port_a_bit_four_oe_n_in,
  .counter_pin_out, .counter_pin_oe_n_out, .underflow_flag_out, .irq_out);
`default_nettype wire

/* tb/cta_pin_src.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// pin source: 0 idle high, 1 held low, 2 square of four cycles
module cta_pin_src
(
  input  wire logic       core_clk_in,
  input  wire logic [1:0] shape_in,
  output var  logic       pin_out
);
  logic [1:0] phase;
  always_ff @(posedge core_clk_in)
  begin
    phase <= (shape_in == 2'h2) ? phase + 2'h1 : 2'h0;
  end
  // two cycles per level keeps edges at half the clock rate
  assign pin_out = (shape_in == 2'h2) ? phase[1] : (shape_in == 2'h0);
endmodule
`default_nettype wire

/* tb/cta_timer_test.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// bench
module cta_timer_test
  import cta_pkg::*;
;
  logic         core_clk_in;
  logic         reset_in;
  cta_bus_req_t bus;
  logic [1:0]   mode;
  logic [1:0]   shape;
  logic         irq_en;
  logic         serial;
  logic         pa;
  logic         pa_oe_n;
  logic [7:0]   rdata;
  logic         rv;
  logic         pin_o;
  logic         pin_oe_n;
  logic         flag;
  logic         irq;
  logic         src_pin;
  logic         tick;
  int           gap;
  logic [7:0]   got;
  logic [7:0]   first;
  int           err_count;
  int           total_checks;
  wire          pin_w = pin_oe_n ? src_pin : pin_o;

  cta_timer cta_timer_i (.core_clk_in(core_clk_in), .reset_in(reset_in), .bus_in(bus), .rdata_out(rdata),
    .rdata_valid_out(rv), .mode_select_in(mode), .underflow_irq_enable_in(irq_en),
    .serial_internal_clk_in(serial), .port_a_bit_four_in(pa), .port_a_bit_four_oe_n_in(pa_oe_n),
    .counter_pin_in(pin_w), .counter_pin_out(pin_o), .counter_pin_oe_n_out(pin_oe_n),
    .underflow_flag_out(flag), .irq_out(irq), .bit_tick_out(tick));
  cta_pin_src cta_pin_src_i (.core_clk_in(core_clk_in), .shape_in(shape), .pin_out(src_pin));

  // ============================================================
  // tasks
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] act);
    total_checks++;
    if (act !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, act);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk_in);
    bus <= '{rd, !rd, addr, data};
    @(posedge core_clk_in);
    bus <= '0;
    #1;
    got = rdata;
    if (rd)
      chk("valid", 8'h1, {7'h0, rv});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ============================================================
  // clock, reset, watchdog, tests
  initial
  begin
    core_clk_in = 0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial
  begin
    #20000;
    err_count++;
    tally_and_finish;
  end
  initial
  begin
    {reset_in, bus, mode, shape, irq_en, serial, pa, pa_oe_n} = {1'b1, 18'h0, 2'h0, 2'h0, 4'b1011};
    err_count = 0;
    total_checks = 0;
    repeat (12) @(posedge core_clk_in);
    reset_in <= 0;
    cyc(1);
    chk("flag", 8'h0, {7'h0, flag});
    access(0, 8'h18, 8'h05);
    access(0, 8'h1a, 8'h01);
    access(1, 8'h18, 8'h00);
    chk("count lo", 8'h04, got);
    for (int i = 0; i < 400 && flag !== 1'b1; i++) cyc(1);
    chk("flag", 8'h1, {7'h0, flag});
    chk("irq", 8'h1, {7'h0, irq});
    access(1, 8'h19, 8'h00);
    chk("count hi", 8'h01, got);
    chk("flag", 8'h1, {7'h0, flag});
    access(1, 8'h18, 8'h00);
    chk("flag", 8'h0, {7'h0, flag});
    @(posedge core_clk_in);
    mode <= CTA_MODE_PULSE;
    cyc(3);
    chk("pulse pin", 8'h1, {7'h0, pin_o});
    access(0, 8'h1a, 8'h00);
    chk("pulse pin", 8'h0, {7'h0, pin_o});
    for (int i = 0; i < 20 && pin_o !== 1'b1; i++) cyc(1);
    chk("pulse pin", 8'h1, {7'h0, pin_o});
    @(posedge core_clk_in);
    {mode, pa, pa_oe_n} <= {CTA_MODE_INTERVAL, 2'b00};
    cyc(2);
    chk("port pin", 8'h0, {6'h0, pin_o, pin_oe_n});
    @(posedge core_clk_in);
    {mode, shape} <= {CTA_MODE_EVENT, 2'h1};
    access(0, 8'h1a, 8'h00);
    @(posedge core_clk_in);
    shape <= 2'h2;
    cyc(11);
    @(posedge core_clk_in);
    shape <= 2'h1;
    cyc(8);
    access(1, 8'h18, 8'h00);
    chk("events", 8'h02, got);
    @(posedge core_clk_in);
    {mode, shape} <= {CTA_MODE_WIDTH, 2'h0};
    cyc(4);
    access(0, 8'h1a, 8'h00);
    cyc(4);
    access(1, 8'h18, 8'h00);
    chk("width hold", 8'h05, got);
    @(posedge core_clk_in);
    shape <= 2'h1;
    cyc(2);
    @(posedge core_clk_in);
    shape <= 2'h0;
    cyc(8);
    access(1, 8'h18, 8'h00);
    chk("width low", 8'h02, got);
    @(posedge core_clk_in);
    serial <= 1;
    access(0, 8'h1a, 8'h00);
    access(1, 8'h18, 8'h00);
    first = got;
    access(1, 8'h18, 8'h00);
    chk("forced step", 8'h02, first - got);
    access(1, 8'h1b, 8'h00);
    chk("unmapped", 8'h00, got);
    access(0, 8'h18, 8'h03);
    access(0, 8'h1a, 8'h00);
    for (int i = 0; i < 200 && tick !== 1'b1; i++) cyc(1);
    cyc(1);
    for (gap = 1; gap < 200 && tick !== 1'b1; gap++) cyc(1);
    chk("bit gap", 8'h40, 8'(gap));
    tally_and_finish;
  end
endmodule
`default_nettype wire
